// ==== bench/unaligned_word_load_unit_test.sv ====
// Self-checking bench for the unaligned word load unit
`timescale 1ns/100ps
module unaligned_word_load_unit_test;
    localparam logic [5:0] UP = wload_pkg::OP_LOAD_PARTIAL_UPPER;
    localparam logic [5:0] LO = wload_pkg::OP_LOAD_PARTIAL_LOWER;
    localparam logic [5:0] FU = wload_pkg::OP_LOAD_FULL_ZERO_EXTENDED;
    logic             SYS_CLK_I = 1'b0;
    logic             SYS_RST_I = 1'b1;
    logic             ISSUE_VALID_I = 1'b0;
    logic [31:0]      INSTR_I = 32'h0;
    logic [63:0]      BASE_VALUE_I = 64'h0;
    logic [63:0]      TARGET_VALUE_I = 64'h0;
    wload_pkg::mode_s MODE_I = '0;
    logic             slow = 1'b0;
    logic [1:0]       fault = 2'h0;
    logic [63:0]      word = 64'h0;
    logic             XLATE_REQ_O, XLATE_DONE_I, XLATE_REFILL_I, XLATE_INVALID_I, MEM_REQ_O;
    logic             MEM_DONE_I, MEM_ERR_I, BUSY_O, WB_VALID_O, EXC_VALID_O;
    logic [63:0]      VADDR_O, MEM_DATA_I, WB_DATA_O;
    logic [35:0]      PADDR_I, MEM_ADDR_O;
    logic [1:0]       MEM_TYPE_O;
    logic [4:0]       WB_REG_O;
    wload_pkg::exc_s  EXC_O;
    logic [63:0]      gpr [32];
    integer           seed = 94149;
    int               err_total = 0;
    int               n_tests = 0;
    always #10 SYS_CLK_I = ~SYS_CLK_I;
    wload_unit i_dut (.SYS_CLK_I, .SYS_RST_I, .ISSUE_VALID_I, .INSTR_I, .BASE_VALUE_I,
        .TARGET_VALUE_I, .MODE_I, .XLATE_REQ_O, .VADDR_O, .XLATE_DONE_I, .PADDR_I,
        .XLATE_REFILL_I, .XLATE_INVALID_I, .MEM_REQ_O, .MEM_ADDR_O, .MEM_TYPE_O, .MEM_DONE_I,
        .MEM_ERR_I, .MEM_DATA_I, .BUSY_O, .WB_VALID_O, .WB_REG_O, .WB_DATA_O, .EXC_VALID_O, .EXC_O);
    wload_far_end i_far (.clk_i(SYS_CLK_I), .slow_i(slow), .fault_i(fault), .word_i(word),
        .xlate_req_i(XLATE_REQ_O), .vaddr_i(VADDR_O), .xlate_done_o(XLATE_DONE_I),
        .paddr_o(PADDR_I), .refill_o(XLATE_REFILL_I), .invalid_o(XLATE_INVALID_I),
        .mem_req_i(MEM_REQ_O), .mem_done_o(MEM_DONE_I), .mem_err_o(MEM_ERR_I),
        .mem_data_o(MEM_DATA_I));
    task automatic chk(input bit ok, input string what);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t: %s", $time, what);
        end
    endtask : chk
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // Chained ops keep one target so the write-back must be forwarded
    task automatic run_op(input logic [5:0] opc, input logic [4:0] t, input bit b2b);
        logic [63:0]     ea, res, old;
        logic [35:0]     pa;
        logic [31:0]     mw, tmp;
        logic [1:0]      b;
        wload_pkg::exc_s ex;
        int              i;
        ex = '0;
        if (!b2b) @(negedge SYS_CLK_I);
        for (i = 0; i < 20 && BUSY_O !== 1'b0; i++) @(negedge SYS_CLK_I);
        chk(i < 20, "still busy before issue");
        if (i >= 20) finish_test();
        MODE_I = wload_pkg::mode_s'(5'($random(seed)));
        BASE_VALUE_I = {$random(seed), $random(seed)};
        INSTR_I = {opc, 5'h3, t, 16'($random(seed))};
        slow = 1'($random(seed));
        fault = (($random(seed) & 7) == 0) ? 2'($random(seed)) : 2'h0;
        word = {$random(seed), $random(seed)};
        old = gpr[t];
        TARGET_VALUE_I = (WB_VALID_O === 1'b1) ? ~old : old;
        ISSUE_VALID_I = 1'b1;
        ea = BASE_VALUE_I + {{48{INSTR_I[15]}}, INSTR_I[15:0]};
        b = ea[1:0] ^ {2{MODE_I.core_byte_order_flag}};
        mw = (ea[2] ^ MODE_I.core_byte_order_flag) ? word[63:32] : word[31:0];
        pa = ea[35:0] ^ 36'ha00000000;
        pa[2:0] = pa[2:0] ^ {3{MODE_I.user_byte_swap_flag}};
        if (opc == UP && !MODE_I.memory_byte_order_flag) pa[1:0] = 2'h0;
        if (opc == LO && MODE_I.memory_byte_order_flag) pa[2:0] = 3'h0;
        tmp = (opc == UP) ? (mw << (24 - 8 * b)) | (old[31:0] & ((32'h1 << (24 - 8 * b)) - 1))
            : (mw >> (8 * b)) | (old[31:0] & ~(32'hffffffff >> (8 * b)));
        res = (opc == FU) ? {32'h0, mw} : MODE_I.mode64 ? {{32{tmp[31]}}, tmp} : {old[63:32], tmp};
        if (opc == FU && !MODE_I.mode64 && !MODE_I.kernel) ex.reserved_instr = 1'b1;
        else if (opc == FU && ea[1:0] != 2'h0) ex.address_error = 1'b1;
        else if (fault == 2'h1) ex.tlb_refill = 1'b1;
        else if (fault == 2'h2) ex.tlb_invalid = 1'b1;
        else if (fault == 2'h3) ex.bus_error = 1'b1;
        @(negedge SYS_CLK_I);
        ISSUE_VALID_I = 1'b0;
        for (i = 0; i < 40 && WB_VALID_O !== 1'b1 && EXC_VALID_O !== 1'b1; i++)
            @(negedge SYS_CLK_I);
        chk(i < 40, "no completion");
        if (i >= 40) finish_test();
        if (!ex.reserved_instr && !ex.address_error)
            chk(VADDR_O === ea, "effective address");
        if (ex !== '0) begin
            chk(EXC_VALID_O === 1'b1 && EXC_O === ex && WB_VALID_O === 1'b0, "exception");
        end else begin
            chk(WB_VALID_O === 1'b1 && WB_REG_O === t, "write-back target");
            chk(MEM_ADDR_O === pa, "memory address");
            chk(MEM_TYPE_O === (opc == UP ? b : opc == LO ? 2'h3 - b : 2'h3), "access type");
            chk(WB_DATA_O === res, "load data");
            gpr[t] = res;
        end
    endtask : run_op
    initial begin
        for (int k = 0; k < 32; k++) gpr[k] = {$random(seed), $random(seed)};
        repeat (5) @(posedge SYS_CLK_I);
        @(negedge SYS_CLK_I);
        SYS_RST_I = 1'b0;
        INSTR_I = 32'h8c000000;
        ISSUE_VALID_I = 1'b1;
        @(negedge SYS_CLK_I);
        ISSUE_VALID_I = 1'b0;
        chk(BUSY_O === 1'b0 && XLATE_REQ_O === 1'b0, "unknown opcode taken");
        for (int n = 0; n < 400; n++)
            run_op(n % 3 == 0 ? UP : n % 3 == 1 ? LO : FU, 5'(n / 8 + 1), n % 8 != 0);
        finish_test();
    end
endmodule : unaligned_word_load_unit_test

// ==== bench/wload_checker_props.sv ====
// Port assertions for the word load unit
`timescale 1ns/100ps
module wload_checker #(
    parameter int PADDR_W = 36
) (
    // Clock, reset, issue
    input wire logic               SYS_CLK_I,
    input wire logic               SYS_RST_I,
    input wire logic               ISSUE_VALID_I,
    input wire logic [31:0]        INSTR_I,
    input wire logic [63:0]        BASE_VALUE_I,
    input wire wload_pkg::mode_s   MODE_I,
    // Far side
    input wire logic               XLATE_DONE_I,
    input wire logic               XLATE_REFILL_I,
    input wire logic               XLATE_REQ_O,
    input wire logic [63:0]        VADDR_O,
    input wire logic               MEM_REQ_O,
    input wire logic [PADDR_W-1:0] MEM_ADDR_O,
    input wire logic [1:0]         MEM_TYPE_O,
    // Result
    input wire logic               BUSY_O,
    input wire logic               WB_VALID_O,
    input wire logic [63:0]        WB_DATA_O,
    input wire logic               EXC_VALID_O,
    input wire wload_pkg::exc_s    EXC_O
);
    localparam logic [5:0] UP = wload_pkg::OP_LOAD_PARTIAL_UPPER;
    localparam logic [5:0] LO = wload_pkg::OP_LOAD_PARTIAL_LOWER;
    localparam logic [5:0] FU = wload_pkg::OP_LOAD_FULL_ZERO_EXTENDED;
    logic             take;
    logic [5:0]       op;
    logic [5:0]       held_op;
    logic [1:0]       bsel;
    logic [63:0]      ea;
    wload_pkg::mode_s held_mode;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    assign op = INSTR_I[31:26];
    assign take = ISSUE_VALID_I && !BUSY_O && (op == UP || op == LO || op == FU);
    assign ea = BASE_VALUE_I + {{48{INSTR_I[15]}}, INSTR_I[15:0]};
    assign bsel = VADDR_O[1:0] ^ {2{held_mode.core_byte_order_flag}};
    // Op and mode kept so later phases can be judged against their own issue
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            held_op <= 6'h00;
            held_mode <= '0;
        end else if (take) begin
            held_op <= op;
            held_mode <= MODE_I;
        end
    end
    issue_answer_a: assert property (take |=> XLATE_REQ_O || EXC_VALID_O)
        else $error("accepted issue not answered");
    vaddr_form_a: assert property (take |=> VADDR_O == $past(ea))
        else $error("effective address wrong");
    partial_no_align_a: assert property (take && op != FU |=> !EXC_VALID_O)
        else $error("partial load raised exception at issue");
    full_reserved_a: assert property (take && op == FU && !MODE_I.mode64 && !MODE_I.kernel
        |=> EXC_VALID_O && EXC_O.reserved_instr) else $error("reserved not raised");
    full_misalign_a: assert property (take && op == FU && (MODE_I.mode64 || MODE_I.kernel)
        && ea[1:0] != 2'h0 |=> EXC_VALID_O && EXC_O.address_error) else $error("no align error");
    upper_mask_a: assert property (MEM_REQ_O && held_op == UP
        && !held_mode.memory_byte_order_flag |-> MEM_ADDR_O[1:0] == 2'h0) else $error("low bits");
    lower_mask_a: assert property (MEM_REQ_O && held_op == LO
        && held_mode.memory_byte_order_flag |-> MEM_ADDR_O[2:0] == 3'h0) else $error("low bits");
    access_type_a: assert property (MEM_REQ_O && held_op != FU |-> MEM_TYPE_O
        == (held_op == UP ? bsel : 2'h3 - bsel)) else $error("access type wrong");
    full_zero_a: assert property (WB_VALID_O && held_op == FU |-> WB_DATA_O[63:32] == 32'h0)
        else $error("full load not zero extended");
    sign_fill_a: assert property (WB_VALID_O && held_op != FU && held_mode.mode64
        |-> WB_DATA_O[63:32] == {32{WB_DATA_O[31]}}) else $error("no sign extension");
    refill_exc_a: assert property (XLATE_DONE_I && XLATE_REFILL_I && BUSY_O
        |=> EXC_VALID_O && EXC_O.tlb_refill) else $error("refill not raised");
    cover property (take && op == FU);
    cover property (WB_VALID_O && held_op == LO);
    cover property (EXC_VALID_O && EXC_O.bus_error);
endmodule : wload_checker
bind wload_unit wload_checker #(.PADDR_W(PADDR_W)) i_chk (.SYS_CLK_I, .SYS_RST_I,
    .ISSUE_VALID_I, .INSTR_I, .BASE_VALUE_I, .MODE_I, .XLATE_DONE_I, .XLATE_REFILL_I,
    .XLATE_REQ_O, .VADDR_O, .MEM_REQ_O, .MEM_ADDR_O, .MEM_TYPE_O, .BUSY_O, .WB_VALID_O,
    .WB_DATA_O, .EXC_VALID_O, .EXC_O);

// ==== bench/wload_far_end.sv ====
// Translation and memory model on the far side of the load unit
`timescale 1ns/100ps
module wload_far_end #(
    parameter int PADDR_W = 36
) (
    // Bench control
    input  wire logic               clk_i,
    input  wire logic               slow_i,
    input  wire logic [1:0]         fault_i,
    input  wire logic [63:0]        word_i,
    // Translation
    input  wire logic               xlate_req_i,
    input  wire logic [63:0]        vaddr_i,
    output logic                    xlate_done_o = 1'b0,
    output logic [PADDR_W-1:0]      paddr_o = '1,
    output logic                    refill_o = 1'b1,
    output logic                    invalid_o = 1'b1,
    // Memory
    input  wire logic               mem_req_i,
    output logic                    mem_done_o = 1'b0,
    output logic                    mem_err_o = 1'b1,
    output logic [63:0]             mem_data_o = '1
);
    // High bits flipped so a missed translation cannot pass
    localparam logic [PADDR_W-1:0] XOR_HI = PADDR_W'(36'ha00000000);
    // Answer lines are inverted outside the answer cycle, never left stale
    always @(posedge clk_i) begin
        if (xlate_req_i) begin
            repeat (slow_i ? 3 : 0) @(posedge clk_i);
            xlate_done_o <= 1'b1;
            paddr_o <= vaddr_i[PADDR_W-1:0] ^ XOR_HI;
            refill_o <= (fault_i == 2'h1);
            invalid_o <= (fault_i == 2'h2);
            @(posedge clk_i);
            xlate_done_o <= 1'b0;
            paddr_o <= ~paddr_o;
            refill_o <= ~refill_o;
            invalid_o <= ~invalid_o;
        end
    end
    always @(posedge clk_i) begin
        if (mem_req_i) begin
            repeat (slow_i ? 2 : 0) @(posedge clk_i);
            mem_done_o <= 1'b1;
            mem_err_o <= (fault_i == 2'h3);
            mem_data_o <= word_i;
            @(posedge clk_i);
            mem_done_o <= 1'b0;
            mem_err_o <= ~mem_err_o;
            mem_data_o <= ~word_i;
        end
    end
endmodule : wload_far_end

// ==== core/lane_merge.sv ====
// Byte-lane merge of a partial or full memory word into a target value
`timescale 1ns/100ps
module lane_merge (
    // Operation select
    input  wire logic        upper_i,
    input  wire logic        lower_i,
    input  wire logic        full_i,
    input  wire logic        mode64_i,
    input  wire logic [1:0]  byte_i,
    input  wire logic        word_i,
    // Data
    input  wire logic [63:0] mem_i,
    input  wire logic [63:0] old_i,
    output logic      [63:0] result_o
);
    logic [31:0] mem_word;
    logic [31:0] temp;
    logic [4:0]  sh;

    always_comb begin
        mem_word = word_i ? mem_i[63:32] : mem_i[31:0];
        sh       = {byte_i, 3'b000};
        temp     = old_i[31:0];
        if (upper_i) begin
            // Addressed byte lands in bit 31 downward; low lanes kept
            temp = (mem_word << (5'd24 - sh)) | (old_i[31:0] & ~(32'hffffffff << (5'd24 - sh)));
        end else if (lower_i) begin
            // Addressed byte lands in bit 0 upward; high lanes kept
            temp = (mem_word >> sh) | (old_i[31:0] & ~(32'hffffffff >> sh));
        end else if (full_i) begin
            temp = mem_word;
        end
        if (full_i) begin
            result_o = {32'h0, temp};
        end else if (mode64_i) begin
            result_o = {{32{temp[31]}}, temp};
        end else begin
            // 32-bit mode keeps the merged word as is
            result_o = {old_i[63:32], temp};
        end
    end
endmodule : lane_merge

// ==== core/wload_pkg.sv ====
// Constants and carrier types for the unaligned word load unit
package wload_pkg;
    localparam logic [5:0] OP_LOAD_PARTIAL_UPPER      = 6'h22;
    localparam logic [5:0] OP_LOAD_PARTIAL_LOWER      = 6'h26;
    localparam logic [5:0] OP_LOAD_FULL_ZERO_EXTENDED = 6'h2f;
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 26;
    localparam int BASE_MSB   = 25;
    localparam int BASE_LSB   = 21;
    localparam int TGT_MSB    = 20;
    localparam int TGT_LSB    = 16;
    localparam int OFFSET_MSB = 15;
    localparam logic [63:0] RESET_DATA = 64'h0;
    localparam logic [2:0]  RESET_OFFSET = 3'h0;
    localparam logic [1:0]  RESET_TYPE = 2'h0;
    localparam logic [4:0]  RESET_REG = 5'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } state_e;

    typedef struct packed {
        logic        kernel;
        logic        mode64;
        logic        memory_byte_order_flag;
        logic        core_byte_order_flag;
        logic        user_byte_swap_flag;
    } mode_s;

    typedef struct packed {
        logic tlb_refill;
        logic tlb_invalid;
        logic bus_error;
        logic address_error;
        logic reserved_instr;
    } exc_s;
endpackage : wload_pkg

// ==== core/wload_unit.sv ====
// Decode, address and merge datapath for three word-load instructions
`timescale 1ns/100ps
// Functional notes
// - Opcode 100010 in bits 31..26 decodes load-partial-upper with base, target, offset.
// - Opcode 100110 decodes load-partial-lower with the same field layout.
// - Opcode 101111 decodes load-full-zero-extended with the same field layout.
// - Address is base register plus sign-extended 16-bit offset, byte granular.
// - Upper and lower partial loads together assemble a word across a boundary.
// - Each partial load reads only the aligned word holding the byte.
// - Upper load puts addressed byte in MSB onward, lower bytes kept.
// - Lower load puts addressed byte in LSB onward, upper bytes kept.
// - In 64-bit mode partial results sign-extend from bit 31.
// - Pending target value is forwarded so back-to-back loads need no gap.
// - Partial loads never raise an alignment address error.
// - Little-endian upper load: type equals low bits, offset 0 or 4.
// - Little-endian lower load: type 3 minus n mod 4, offset n.
// - Upper load with little-endian memory clears physical address bits 1..0.
// - Lower load with big-endian memory clears physical address bits 2..0.
// - Full load zero-extends the word into the upper register bits.
// - Full load raises address error if either low address bit set.
// - Full load is reserved in 32-bit user or supervisor mode.
module wload_unit #(
    parameter int PADDR_W = 36
) (
    // Clock and reset
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 SYS_RST_I,
    // Instruction issue
    input  wire logic                 ISSUE_VALID_I,
    input  wire logic [31:0]          INSTR_I,
    input  wire logic [63:0]          BASE_VALUE_I,
    input  wire logic [63:0]          TARGET_VALUE_I,
    input  wire wload_pkg::mode_s     MODE_I,
    // Address translation
    output logic                      XLATE_REQ_O,
    output logic [63:0]               VADDR_O,
    input  wire logic                 XLATE_DONE_I,
    input  wire logic [PADDR_W-1:0]   PADDR_I,
    input  wire logic                 XLATE_REFILL_I,
    input  wire logic                 XLATE_INVALID_I,
    // Memory
    output logic                      MEM_REQ_O,
    output logic [PADDR_W-1:0]        MEM_ADDR_O,
    output logic [1:0]                MEM_TYPE_O,
    input  wire logic                 MEM_DONE_I,
    input  wire logic                 MEM_ERR_I,
    input  wire logic [63:0]          MEM_DATA_I,
    // Result
    output logic                      BUSY_O,
    output logic                      WB_VALID_O,
    output logic [4:0]                WB_REG_O,
    output logic [63:0]               WB_DATA_O,
    output logic                      EXC_VALID_O,
    output wload_pkg::exc_s           EXC_O
);
    wload_pkg::state_e state;
    wload_pkg::state_e next_state;

    logic [5:0]         op;
    logic               dec_upper;
    logic               dec_lower;
    logic               dec_full;
    logic [63:0]        eff_addr;
    logic               accept;

    logic               upper;
    logic               lower;
    logic               full;
    logic               mode64;
    logic               mem_be;
    logic               cpu_be;
    logic               swap;
    logic [4:0]         tgt;
    logic [63:0]        old_val;
    logic [63:0]        vaddr;
    logic               xlate_req;
    logic               mem_req;
    logic [PADDR_W-1:0] mem_addr;
    logic [1:0]         mem_type;
    logic               wb_valid;
    logic [4:0]         wb_reg;
    logic [63:0]        wb_data;
    logic               exc_valid;
    wload_pkg::exc_s    exc;
    logic               busy;
    logic               next_busy;

    logic               next_upper;
    logic               next_lower;
    logic               next_full;
    logic               next_mode64;
    logic               next_mem_be;
    logic               next_cpu_be;
    logic               next_swap;
    logic [4:0]         next_tgt;
    logic [63:0]        next_old_val;
    logic [63:0]        next_vaddr;
    logic               next_xlate_req;
    logic               next_mem_req;
    logic [PADDR_W-1:0] next_mem_addr;
    logic [1:0]         next_mem_type;
    logic               next_wb_valid;
    logic [4:0]         next_wb_reg;
    logic [63:0]        next_wb_data;
    logic               next_exc_valid;
    wload_pkg::exc_s    next_exc;

    logic [1:0]         byte_sel;
    logic               word_sel;
    logic [PADDR_W-1:0] pa;
    logic [63:0]        merged;

    assign op        = INSTR_I[wload_pkg::OPCODE_MSB:wload_pkg::OPCODE_LSB];
    assign dec_upper = (op == wload_pkg::OP_LOAD_PARTIAL_UPPER);
    assign dec_lower = (op == wload_pkg::OP_LOAD_PARTIAL_LOWER);
    assign dec_full  = (op == wload_pkg::OP_LOAD_FULL_ZERO_EXTENDED);
    assign eff_addr  = BASE_VALUE_I
                     + {{48{INSTR_I[wload_pkg::OFFSET_MSB]}}, INSTR_I[15:0]};
    assign accept    = ISSUE_VALID_I && (state == wload_pkg::ST_IDLE)
                     && (dec_upper || dec_lower || dec_full);

    // Byte and word selects from the virtual address and core byte order
    assign byte_sel = vaddr[1:0] ^ {2{cpu_be}};
    assign word_sel = vaddr[2] ^ cpu_be;

    lane_merge u_merge (
        .upper_i  (upper),
        .lower_i  (lower),
        .full_i   (full),
        .mode64_i (mode64),
        .byte_i   (byte_sel),
        .word_i   (word_sel),
        .mem_i    (MEM_DATA_I),
        .old_i    (old_val),
        .result_o (merged)
    );

    always_comb begin
        next_state     = state;
        next_upper     = upper;
        next_lower     = lower;
        next_full      = full;
        next_mode64    = mode64;
        next_mem_be    = mem_be;
        next_cpu_be    = cpu_be;
        next_swap      = swap;
        next_tgt       = tgt;
        next_old_val   = old_val;
        next_vaddr     = vaddr;
        next_xlate_req = 1'b0;
        next_mem_req   = 1'b0;
        next_mem_addr  = mem_addr;
        next_mem_type  = mem_type;
        next_wb_valid  = 1'b0;
        next_wb_reg    = wb_reg;
        next_wb_data   = wb_data;
        next_exc_valid = 1'b0;
        next_exc       = exc;
        pa             = PADDR_I;
        unique case (state)
            wload_pkg::ST_IDLE: begin
                if (accept) begin
                    next_upper  = dec_upper;
                    next_lower  = dec_lower;
                    next_full   = dec_full;
                    next_mode64 = MODE_I.mode64;
                    next_mem_be = MODE_I.memory_byte_order_flag;
                    next_cpu_be = MODE_I.core_byte_order_flag;
                    next_swap   = MODE_I.user_byte_swap_flag;
                    next_tgt    = INSTR_I[wload_pkg::TGT_MSB:wload_pkg::TGT_LSB];
                    next_vaddr  = eff_addr;
                    // Bypass a just-written result to the same target
                    if (wb_valid && wb_reg == INSTR_I[wload_pkg::TGT_MSB:wload_pkg::TGT_LSB])
                        next_old_val = wb_data;
                    else
                        next_old_val = TARGET_VALUE_I;
                    next_exc = '0;
                    if (dec_full && !MODE_I.mode64 && !MODE_I.kernel) begin
                        next_exc.reserved_instr = 1'b1;
                        next_exc_valid = 1'b1;
                    end else if (dec_full && eff_addr[1:0] != 2'b00) begin
                        // Only the full load checks alignment
                        next_exc.address_error = 1'b1;
                        next_exc_valid = 1'b1;
                    end else begin
                        next_xlate_req = 1'b1;
                        next_state     = wload_pkg::ST_WAIT;
                    end
                end
            end
            wload_pkg::ST_WAIT: begin
                if (XLATE_DONE_I) begin
                    if (XLATE_REFILL_I || XLATE_INVALID_I) begin
                        next_exc.tlb_refill  = XLATE_REFILL_I;
                        next_exc.tlb_invalid = XLATE_INVALID_I;
                        next_exc_valid       = 1'b1;
                        next_state           = wload_pkg::ST_IDLE;
                    end else begin
                        pa[2:0] = PADDR_I[2:0] ^ {3{swap}};
                        // Aligned word / doubleword only
                        if (upper && !mem_be)
                            pa[1:0] = 2'b00;
                        if (lower && mem_be)
                            pa[2:0] = 3'b000;
                        next_mem_addr = pa;
                        // Access type: byte count minus one
                        if (upper)
                            next_mem_type = byte_sel;
                        else if (lower)
                            next_mem_type = 2'd3 - byte_sel;
                        else
                            next_mem_type = 2'd3;
                        next_mem_req = 1'b1;
                        next_state   = wload_pkg::ST_DONE;
                    end
                end
            end
            wload_pkg::ST_DONE: begin
                if (MEM_DONE_I) begin
                    if (MEM_ERR_I) begin
                        next_exc.bus_error = 1'b1;
                        next_exc_valid     = 1'b1;
                    end else begin
                        next_wb_valid = 1'b1;
                        next_wb_reg   = tgt;
                        next_wb_data  = merged;
                    end
                    next_state = wload_pkg::ST_IDLE;
                end
            end
        endcase
        // Busy drops on the write-back edge so a new issue can follow at once
        next_busy = (next_state != wload_pkg::ST_IDLE);
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state     <= wload_pkg::ST_IDLE;
            upper     <= 1'b0;
            lower     <= 1'b0;
            full      <= 1'b0;
            mode64    <= 1'b0;
            mem_be    <= 1'b0;
            cpu_be    <= 1'b0;
            swap      <= 1'b0;
            tgt       <= wload_pkg::RESET_REG;
            old_val   <= wload_pkg::RESET_DATA;
            vaddr     <= wload_pkg::RESET_DATA;
            xlate_req <= 1'b0;
            mem_req   <= 1'b0;
            mem_addr  <= '0;
            mem_type  <= wload_pkg::RESET_TYPE;
            wb_valid  <= 1'b0;
            wb_reg    <= wload_pkg::RESET_REG;
            wb_data   <= wload_pkg::RESET_DATA;
            exc_valid <= 1'b0;
            exc       <= '0;
            busy      <= 1'b0;
        end else begin
            state     <= next_state;
            upper     <= next_upper;
            lower     <= next_lower;
            full      <= next_full;
            mode64    <= next_mode64;
            mem_be    <= next_mem_be;
            cpu_be    <= next_cpu_be;
            swap      <= next_swap;
            tgt       <= next_tgt;
            old_val   <= next_old_val;
            vaddr     <= next_vaddr;
            xlate_req <= next_xlate_req;
            mem_req   <= next_mem_req;
            mem_addr  <= next_mem_addr;
            mem_type  <= next_mem_type;
            wb_valid  <= next_wb_valid;
            wb_reg    <= next_wb_reg;
            wb_data   <= next_wb_data;
            exc_valid <= next_exc_valid;
            exc       <= next_exc;
            busy      <= next_busy;
        end
    end

    // Busy has its own flop so the port carries no gate after the register
    assign BUSY_O      = busy;
    assign XLATE_REQ_O = xlate_req;
    assign VADDR_O     = vaddr;
    assign MEM_REQ_O   = mem_req;
    assign MEM_ADDR_O  = mem_addr;
    assign MEM_TYPE_O  = mem_type;
    assign WB_VALID_O  = wb_valid;
    assign WB_REG_O    = wb_reg;
    assign WB_DATA_O   = wb_data;
    assign EXC_VALID_O = exc_valid;
    assign EXC_O       = exc;
endmodule : wload_unit
